//--- pkg/cfe_cfg.svh
// Offsets, field positions, reset values and cycle counts of the filter engine.
// Assumes inclusion by bare name.
`ifndef CFE_CFG_SVH
`define CFE_CFG_SVH

// Byte offsets of the register map.
`define CFE_OFF_CTRL     12'h000
`define CFE_OFF_STATUS   12'h004
`define CFE_OFF_COST     12'h008
`define CFE_OFF_CH0      12'h010
`define CFE_OFF_CH1      12'h020
`define CFE_OFF_POOL     12'h200
// Offsets inside a channel block.
`define CFE_SUB_CFG      2'h0
`define CFE_SUB_IN       2'h1
`define CFE_SUB_OUT      2'h2

// Field positions.
`define CFE_CTRL_RUN     0
`define CFE_CTRL_INTEN   1
`define CFE_CFG_EN       0
`define CFE_CFG_MODE     1
`define CFE_CFG_TAPS     8
`define CFE_CFG_ORDER    16
`define CFE_CFG_BASE     24
`define CFE_ST_READY     0
`define CFE_ST_OVR       2
`define CFE_ST_BUSY      4

// Reset values.
`define CFE_CTRL_RST     2'h0
`define CFE_CFG_RST      24'h000000

// Per-sample cycle cost terms.
`define CFE_CYC_FIR      10'h00A
`define CFE_CYC_BQ_EVEN  10'h00D
`define CFE_CYC_BQ_ODD   10'h012
`define CFE_CYC_MIX_EVEN 10'h014
`define CFE_CYC_MIX_ODD  10'h019
`define CFE_CYC_PER_ORD  10'h005

// Bus responses.
`define CFE_RESP_OKAY    2'h0
`define CFE_RESP_SLVERR  2'h2

`endif

//--- pkg/cfe_pkg.sv
// Types shared by the filter engine and its cost calculator.
// Assumes nothing of its surroundings.
package cfe_pkg;

  // How a channel announces a new output sample.
  typedef enum logic [1:0]
  {
    CFE_MODE_POLL = 2'h0,
    CFE_MODE_IRQ  = 2'h1,
    CFE_MODE_DMA  = 2'h2
  } cfe_mode_t;

  // Sequencer states, one-hot.
  typedef enum logic [2:0]
  {
    CFE_ST_IDLE = 3'h1,
    CFE_ST_RUN  = 3'h2,
    CFE_ST_DONE = 3'h4
  } cfe_state_t;

  // Configuration of one channel; pool indices are 7 bits for 128 words.
  typedef struct packed
  {
    logic [6:0] base;
    logic [6:0] order;
    logic [6:0] taps;
    cfe_mode_t  mode;
    logic       en;
  } cfe_chan_cfg_t;

endpackage : cfe_pkg

//--- core/cfe_chan_cost.sv
// Per-sample cycle cost of one filter channel.
// Assumes a stable configuration; purely combinational.
`timescale 1ns/1ps
`include "cfe_cfg.svh"
module cfe_chan_cost
  import cfe_pkg::*;
(
  input  wire cfe_chan_cfg_t cfg,
  output logic [9:0]         cost
);

  logic [9:0] taps_w;
  logic [9:0] ord5;

  assign taps_w = {3'h0, cfg.taps};
  assign ord5   = 10'({3'h0, cfg.order} * `CFE_CYC_PER_ORD);

  // Overhead depends on the mix of section kinds and on order parity.
  always_comb
  begin
    cost = 10'h000;
    if (!cfg.en)
      cost = 10'h000;
    else if (cfg.order == 7'h00)
      cost = `CFE_CYC_FIR + taps_w;
    else if (cfg.taps == 7'h00 && !cfg.order[0])
      cost = `CFE_CYC_BQ_EVEN + ord5;
    else if (cfg.taps == 7'h00)
      cost = `CFE_CYC_BQ_ODD + ord5;
    else if (!cfg.order[0])
      cost = `CFE_CYC_MIX_EVEN + taps_w + ord5;
    else
      cost = `CFE_CYC_MIX_ODD + taps_w + ord5;
  end

endmodule : cfe_chan_cost

//--- core/cfe_engine.sv
// Two-channel cascade filter engine with a shared coefficient and data pool.
// Assumes an AXI4-Lite master on aclk and a DMA or CPU reading results.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "cfe_cfg.svh"

module cfe_engine
  import cfe_pkg::*;
#(
  parameter int AW = 12,
  parameter int SW = 16
)
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic               irq,
  output logic [1:0]         dma_req
);

  localparam int ACCW = 2 * SW + 8;

  // Register file and channel state.
  logic [1:0]          ctrl;
  cfe_chan_cfg_t       cfg [2];
  logic [9:0]          cost [2];
  logic [10:0]         total_cost;
  logic [SW-1:0]       pool [128];
  logic [SW-1:0]       in_sample [2];
  logic [SW-1:0]       out_hold [2];
  logic [SW-1:0]       stage_val;
  logic [1:0]          pending;
  logic [1:0]          ready;
  logic [1:0]          ovr;

  // Bus side bookkeeping.
  logic                aw_got;
  logic                w_got;
  logic [AW-1:0]       aw_q;
  logic [31:0]         w_q;
  logic                wr_fire;
  logic                rd_fire;
  logic [31:0]         rd_data;
  logic                rd_err;

  // Write decode of the held address, and the OUT read flags.
  logic                wr_ctrl;
  logic                wr_status;
  logic                wr_pool;
  logic [1:0]          wr_cfg;
  logic [1:0]          wr_in;
  logic                wr_err;
  logic [1:0]          rd_out;

  // Sequencer.
  cfe_state_t          state;
  logic                ch_sel;
  logic [9:0]          cnt;
  logic [6:0]          k;
  logic                mac_on;
  logic signed [ACCW-1:0] acc;
  logic [SW-1:0]       x_cur;
  logic [6:0]          coef_idx;
  logic [6:0]          data_idx;
  logic [6:0]          prev_idx;
  logic                eng_wr;
  logic [1:0]          done_ch;

  // The cost of each channel comes from its own calculator instance, one per channel.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_cost
      cfe_chan_cost u_cost
      (
        .cfg  (cfg[gi]),
        .cost (cost[gi])
      );
    end
  endgenerate

  // Total budget is registered so software reads a settled value.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      total_cost <= 11'h000;
    else
      total_cost <= {1'b0, cost[0]} + {1'b0, cost[1]};
  end

  assign wr_fire = aw_got && w_got && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // Write address channel; one write in flight.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got        <= 1'b0;
      aw_q          <= '0;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got        <= 1'b1;
      aw_q          <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (wr_fire)
      aw_got <= 1'b0;
    else if (!aw_got && !s_axi_bvalid)
      s_axi_awready <= 1'b1;
  end

  // Write data channel.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_got        <= 1'b0;
      w_q          <= 32'h00000000;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_got        <= 1'b1;
      w_q          <= s_axi_wdata;
      s_axi_wready <= 1'b0;
    end
    else if (wr_fire)
      w_got <= 1'b0;
    else if (!w_got && !s_axi_bvalid)
      s_axi_wready <= 1'b1;
  end

  // Address decode of the held write; partial strobes write the whole word.
  always_comb
  begin
    wr_ctrl   = 1'b0;
    wr_status = 1'b0;
    wr_pool   = 1'b0;
    wr_cfg    = 2'h0;
    wr_in     = 2'h0;
    wr_err    = 1'b0;
    if (aw_q == `CFE_OFF_CTRL)
      wr_ctrl = 1'b1;
    else if (aw_q == `CFE_OFF_STATUS)
      wr_status = 1'b1;
    else if ((aw_q & ~12'h1FC) == `CFE_OFF_POOL)
      wr_pool = 1'b1;
    else if ((aw_q & ~12'h00C) == `CFE_OFF_CH0 && aw_q[3:2] == `CFE_SUB_CFG)
      wr_cfg[0] = 1'b1;
    else if ((aw_q & ~12'h00C) == `CFE_OFF_CH1 && aw_q[3:2] == `CFE_SUB_CFG)
      wr_cfg[1] = 1'b1;
    else if ((aw_q & ~12'h00C) == `CFE_OFF_CH0 && aw_q[3:2] == `CFE_SUB_IN)
      wr_in[0] = 1'b1;
    else if ((aw_q & ~12'h00C) == `CFE_OFF_CH1 && aw_q[3:2] == `CFE_SUB_IN)
      wr_in[1] = 1'b1;
    else if (aw_q != `CFE_OFF_COST)
      wr_err = 1'b1;
  end

  // Write response follows both halves.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CFE_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_err ? `CFE_RESP_SLVERR : `CFE_RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Control and channel configuration registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl   <= `CFE_CTRL_RST;
      cfg[0] <= `CFE_CFG_RST;
      cfg[1] <= `CFE_CFG_RST;
    end
    else if (wr_fire && wr_ctrl)
      ctrl <= w_q[1:0];
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (wr_fire && wr_cfg[c])
        begin
          cfg[c].en    <= w_q[`CFE_CFG_EN];
          cfg[c].mode  <= cfe_mode_t'(w_q[`CFE_CFG_MODE +: 2]);
          cfg[c].taps  <= w_q[`CFE_CFG_TAPS +: 7];
          cfg[c].order <= w_q[`CFE_CFG_ORDER +: 7];
          cfg[c].base  <= w_q[`CFE_CFG_BASE +: 7];
        end
      end
    end
  end

  // Read decode; an OUT read collects that channel's result.
  always_comb
  begin
    rd_data = 32'h00000000;
    rd_err  = 1'b0;
    rd_out  = 2'h0;
    if (s_axi_araddr == `CFE_OFF_CTRL)
      rd_data = {30'h0, ctrl};
    else if (s_axi_araddr == `CFE_OFF_STATUS)
      rd_data = {27'h0, state == CFE_ST_RUN, ovr,
                 ready & {2{ctrl[`CFE_CTRL_INTEN]}}};
    else if (s_axi_araddr == `CFE_OFF_COST)
      rd_data = {21'h0, total_cost};
    else if ((s_axi_araddr & ~12'h1FC) == `CFE_OFF_POOL)
      rd_data = {{(32-SW){1'b0}}, pool[s_axi_araddr[8:2]]};
    else if ((s_axi_araddr & ~12'h00C) == `CFE_OFF_CH0 && s_axi_araddr[3:2] == `CFE_SUB_CFG)
      rd_data = {1'b0, cfg[0].base, 1'b0, cfg[0].order, 1'b0, cfg[0].taps,
                 5'h0, cfg[0].mode, cfg[0].en};
    else if ((s_axi_araddr & ~12'h00C) == `CFE_OFF_CH1 && s_axi_araddr[3:2] == `CFE_SUB_CFG)
      rd_data = {1'b0, cfg[1].base, 1'b0, cfg[1].order, 1'b0, cfg[1].taps,
                 5'h0, cfg[1].mode, cfg[1].en};
    else if ((s_axi_araddr & ~12'h00C) == `CFE_OFF_CH0 && s_axi_araddr[3:2] == `CFE_SUB_OUT)
    begin
      rd_data   = {{(32-SW){out_hold[0][SW-1]}}, out_hold[0]};
      rd_out[0] = 1'b1;
    end
    else if ((s_axi_araddr & ~12'h00C) == `CFE_OFF_CH1 && s_axi_araddr[3:2] == `CFE_SUB_OUT)
    begin
      rd_data   = {{(32-SW){out_hold[1][SW-1]}}, out_hold[1]};
      rd_out[1] = 1'b1;
    end
    else if ((s_axi_araddr & ~12'h00C) != `CFE_OFF_CH0 &&
             (s_axi_araddr & ~12'h00C) != `CFE_OFF_CH1)
      rd_err = 1'b1;
  end

  // Read channel: data one cycle after the address.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CFE_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_err ? `CFE_RESP_SLVERR : `CFE_RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // Input samples: one held per channel; the source sets the real rate.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_sample[0] <= '0;
      in_sample[1] <= '0;
      pending      <= 2'h0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (wr_fire && wr_in[c] && cfg[c].en)
        begin
          in_sample[c] <= w_q[SW-1:0];
          pending[c]   <= 1'b1;
        end
        else if (state == CFE_ST_IDLE && ctrl[`CFE_CTRL_RUN] && x_sel_hit(c))
          pending[c] <= 1'b0;
      end
    end
  end

  // Channel 0 wins when both samples wait.
  function automatic logic x_sel_hit(input int c);
    x_sel_hit = (c == 0) ? pending[0] : (pending[1] && !pending[0]);
  endfunction : x_sel_hit

  assign coef_idx = cfg[ch_sel].base + k;
  assign data_idx = cfg[ch_sel].base + cfg[ch_sel].taps + k;
  assign prev_idx = data_idx - 7'h01;
  assign eng_wr   = (state == CFE_ST_RUN) && mac_on;
  assign done_ch  = (state == CFE_ST_DONE) ? (ch_sel ? 2'h2 : 2'h1) : 2'h0;

  // Sequencer: each channel spends exactly its costed cycles in RUN, plus one IDLE and one DONE cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state     <= CFE_ST_IDLE;
      ch_sel    <= 1'b0;
      cnt       <= 10'h000;
      k         <= 7'h00;
      mac_on    <= 1'b0;
      acc       <= '0;
      x_cur     <= '0;
      stage_val <= '0;
    end
    else
    begin
      case (state)
        CFE_ST_IDLE:
        begin
          if (ctrl[`CFE_CTRL_RUN] && pending != 2'h0)
          begin
            ch_sel <= !pending[0];
            x_cur  <= pending[0] ? in_sample[0] : in_sample[1];
            cnt    <= (pending[0] ? cost[0] : cost[1]) - 10'h001;
            k      <= (pending[0] ? cfg[0].taps : cfg[1].taps) - 7'h01;
            mac_on <= (pending[0] ? cfg[0].taps : cfg[1].taps) != 7'h00;
            acc    <= '0;
            state  <= CFE_ST_RUN;
          end
        end
        CFE_ST_RUN:
        begin
          // Taps are walked from the oldest down so the delay line shifts in place.
          if (mac_on)
          begin
            acc <= acc + ACCW'($signed(pool[coef_idx]) *
                               $signed((k == 7'h00) ? x_cur : pool[prev_idx]));
            if (k == 7'h00)
              mac_on <= 1'b0;
            else
              k <= k - 7'h01;
          end
          // Biquad sections share the single input rate; no stage resamples.
          if (cnt == 10'h000)
          begin
            stage_val <= (cfg[ch_sel].taps == 7'h00) ? x_cur : acc[2*SW-2:SW-1];
            state     <= CFE_ST_DONE;
          end
          else
            cnt <= cnt - 10'h001;
        end
        CFE_ST_DONE:
          state <= CFE_ST_IDLE;
        default:
          state <= CFE_ST_IDLE;
      endcase
    end
  end

  // Pool memory; the engine's shift beats a bus write, so load it stopped.
  always_ff @(posedge aclk)
  begin
    if (eng_wr)
      pool[data_idx] <= (k == 7'h00) ? x_cur : pool[prev_idx];
    else if (wr_fire && wr_pool)
      pool[aw_q[8:2]] <= w_q[SW-1:0];
  end

  // Results move from staging into the holding register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_hold[0] <= '0;
      out_hold[1] <= '0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
        if (done_ch[c])
          out_hold[c] <= stage_val;
    end
  end

  // Ready and overrun flags; a new result wins over a read in the same cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ready <= 2'h0;
      ovr   <= 2'h0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (done_ch[c])
          ready[c] <= 1'b1;
        else if (rd_fire && rd_out[c])
          ready[c] <= 1'b0;
        if (done_ch[c] && ready[c] && !(rd_fire && rd_out[c]))
          ovr[c] <= 1'b1;
        else if (wr_fire && wr_in[c] && cfg[c].en && pending[c])
          ovr[c] <= 1'b1;
        else if (wr_fire && wr_status && w_q[`CFE_ST_OVR + c])
          ovr[c] <= 1'b0;
      end
    end
  end

  // DMA requests: a fresh one only once the last sample was collected.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dma_req <= 2'h0;
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (done_ch[c] && cfg[c].mode == CFE_MODE_DMA && !ready[c])
          dma_req[c] <= 1'b1;
        else if (rd_fire && rd_out[c])
          dma_req[c] <= 1'b0;
      end
    end
  end

  // Shared interrupt follows any unread result of an interrupt-mode channel.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= ctrl[`CFE_CTRL_INTEN] &&
             ((ready[0] && cfg[0].mode == CFE_MODE_IRQ) ||
              (ready[1] && cfg[1].mode == CFE_MODE_IRQ));
  end

endmodule : cfe_engine

//--- sim/cfe_engine_checker.sv
// Concurrent checks on the engine's bus handshakes and data-ready pins.
// Assumes it is bound to cfe_engine and sees only that module's ports.
`timescale 1ns/1ps
`include "cfe_cfg.svh"
module cfe_engine_checker
#(
  parameter int AW = 12
)
(
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic          irq,
  input wire logic [1:0]    dma_req
);
  // Only a read of the channel 0 result may drop its request.
  logic rd_out0;
  assign rd_out0 = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `CFE_OFF_CH0 + 12'h008);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Reset silences all answers and requests.
  property p_reset_quiet;
    disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq && dma_req == 2'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("active after reset");
  property p_w_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_w_lat: assert property (p_w_lat) else $error("write response late");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read data late");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("response repeated");
  // The past term covers the clear's one-cycle lag.
  property p_dma_hold;
    dma_req[0] && !rd_out0 && !$past(rd_out0) |=> dma_req[0];
  endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("request dropped unread");
  property p_dma_fall;
    dma_req[0] && rd_out0 |-> ##[1:2] !dma_req[0];
  endproperty
  a_dma_fall: assert property (p_dma_fall) else $error("request stuck");
  property p_dma_indep;
    $rose(dma_req[0]) |-> $stable(dma_req[1]);
  endproperty
  a_dma_indep: assert property (p_dma_indep) else $error("requests coupled");
  property p_irq_hold;
    irq && !s_axi_arvalid && !$past(s_axi_arvalid) && !s_axi_awvalid && !$past(s_axi_awvalid)
      |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  c_dma: cover property ($rose(dma_req[0]));
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `CFE_RESP_SLVERR);
endmodule : cfe_engine_checker

bind cfe_engine cfe_engine_checker #(.AW(AW)) cfe_engine_checker_inst
(
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .irq, .dma_req
);

//--- sim/cfe_host_model.sv
// Host that moves settings and samples over AXI4-Lite, one transfer at a time.
// Assumes the bench calls its tasks right after a rising edge.
`timescale 1ns/1ps
module cfe_host_model
(
  input wire logic        aclk,
  output logic [11:0]     s_axi_awaddr,
  output logic            s_axi_awvalid,
  input wire logic        s_axi_awready,
  output logic [31:0]     s_axi_wdata,
  output logic [3:0]      s_axi_wstrb,
  output logic            s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  output logic            s_axi_bready,
  output logic [11:0]     s_axi_araddr,
  output logic            s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  output logic            s_axi_rready
);
  // Idle bus at time zero; whole words, all strobes set.
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end

  // Address and data go out together; released lines carry inverted junk.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic dd;
    @(posedge aclk);
    ad = 1'b0;
    dd = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge aclk);
      if (!ad && s_axi_awready === 1'b1)
      begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (!dd && s_axi_wready === 1'b1)
      begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    end
    while (s_axi_bvalid !== 1'b1)
      @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // Read: address held until taken, rready until data is seen.
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
      @(posedge aclk);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    do
      @(posedge aclk);
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : cfe_host_model

//--- sim/dual_channel_cascade_filter_engine_test.sv
// Self-checking bench: a host model feeds the engine, an integer model predicts it.
// Assumes the engine, its checker and the host model are compiled before it.
`timescale 1ns/1ps
`include "cfe_cfg.svh"
module dual_channel_cascade_filter_engine_test
  import cfe_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, dma_req, r;
  int          bad_count, checks_done, cyc, c0, c1, n, x, y, t, o;
  int          hist[$];

  cfe_engine cfe_engine_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .dma_req);
  cfe_host_model cfe_host_model_inst (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // Stimulus randomness comes from this shift register only.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected per-sample cycle cost of one channel.
  function automatic int cost(input int tp, input int od, input int en);
    if (en == 0)
      return 0;
    if (od == 0)
      return 10 + tp;
    if (tp == 0)
      return ((od % 2) ? 18 : 13) + 5 * od;
    return ((od % 2) ? 25 : 20) + tp + 5 * od;
  endfunction : cost

  function automatic logic [31:0] cfg(input int tp, input int od, input int b, input int m);
    return 32'(b * 16777216 + od * 65536 + tp * 256 + m * 2 + 1);
  endfunction : cfg

  // Two-tap FIR, coefficients one half and one quarter.
  function automatic logic [31:0] fir_out();
    int acc;
    acc = 16384 * hist[$];
    if (hist.size() > 1)
      acc += 8192 * hist[$-1];
    return 32'(acc >>> 15);
  endfunction : fir_out

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // One random sample into a channel; the bench sets the pace.
  task automatic send(input int ch);
    seed = lfsr(seed);
    x = int'(seed[13:0]);
    if (ch == 0)
      hist.push_back(x);
    cfe_host_model_inst.wr(ch ? `CFE_OFF_CH1 + 12'h4 : `CFE_OFF_CH0 + 12'h4, 32'(x), r);
  endtask : send

  // Counts edges until irq (which=1) or dma_req[0], at most lim.
  task automatic wait_for(input int which, input int lim);
    n = 0;
    while ((which ? irq : dma_req[0]) !== 1'b1 && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_for

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // A hang is cut short here and counted as a mismatch.
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      final_report();
    end
  end

  initial
  begin
    aresetn = 1'b0;
    seed = 32'h7302;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    cfe_host_model_inst.rd(`CFE_OFF_CTRL, v, r);
    chk("ctrl reset", v, 32'h0);
    cfe_host_model_inst.rd(`CFE_OFF_CH0, v, r);
    chk("cfg reset", v, 32'h0);
    cfe_host_model_inst.wr(12'h100, 32'h1, r);
    chk("unmapped write", 32'(r), 32'(`CFE_RESP_SLVERR));
    cfe_host_model_inst.rd(12'h100, v, r);
    chk("unmapped read", {v[29:0], r}, 32'(`CFE_RESP_SLVERR));
    $display("test registers done");
    // Every enabled cost class on channel 0 against a random FIR or idle channel 1.
    for (int k = 0; k < 5; k++)
    begin
      seed = lfsr(seed);
      t = (k == 1 || k == 2) ? 0 : 1 + int'(seed[3:0]);
      o = (k == 0) ? 0 : 2 * (1 + int'(seed[5:4])) + ((k == 2 || k == 4) ? 1 : 0);
      cfe_host_model_inst.wr(`CFE_OFF_CH0, cfg(t, o, 0, 0), r);
      cfe_host_model_inst.wr(`CFE_OFF_CH1, cfg(int'(seed[9:6]), 0, 64, 0) - 32'(k <= 2), r);
      cfe_host_model_inst.rd(`CFE_OFF_COST, v, r);
      chk("cost", v, 32'(cost(t, o, 1) + cost(int'(seed[9:6]), 0, k > 2)));
    end
    $display("test cost done");
    // Channel 0: two-tap FIR in DMA mode; pool loaded while stopped.
    cfe_host_model_inst.wr(`CFE_OFF_CH1, 32'h0, r);
    for (int k = 0; k < 4; k++)
      cfe_host_model_inst.wr(`CFE_OFF_POOL + 12'(4 * k), (k < 2) ? 32'h4000 >> k : 32'h0, r);
    cfe_host_model_inst.wr(`CFE_OFF_CH0, cfg(2, 0, 0, CFE_MODE_DMA), r);
    cfe_host_model_inst.wr(`CFE_OFF_CTRL, 32'h3, r);
    c0 = cost(2, 0, 1);
    send(0);
    wait_for(0, c0 + 20);
    chk("dma latency", 32'(n >= c0 + 1 && n <= c0 + 2), 32'h1);
    chk("ch1 request", 32'(dma_req[1]), 32'h0);
    cfe_host_model_inst.rd(`CFE_OFF_CH0 + 12'h8, v, r);
    chk("out0", v, fir_out());
    repeat (2) @(posedge aclk);
    chk("dma after read", 32'(dma_req[0]), 32'h0);
    // A result left unread is overwritten without a fresh request.
    send(0);
    wait_for(0, c0 + 20);
    send(0);
    repeat (c0 + 6) @(posedge aclk);
    chk("dma held", 32'(dma_req[0]), 32'h1);
    cfe_host_model_inst.rd(`CFE_OFF_STATUS, v, r);
    chk("status overrun", {27'h0, v[4:0]}, 32'h5);
    cfe_host_model_inst.rd(`CFE_OFF_CH0 + 12'h8, v, r);
    chk("out0 newest", v, fir_out());
    cfe_host_model_inst.wr(`CFE_OFF_STATUS, 32'hC, r);
    $display("test dma done");
    // Both channels in one interval; channel 1 an odd biquad on irq.
    cfe_host_model_inst.wr(`CFE_OFF_CH1, cfg(0, 3, 8, CFE_MODE_IRQ), r);
    c1 = cost(0, 3, 1);
    send(0);
    send(1);
    y = x;
    wait_for(1, c0 + c1 + 6);
    chk("irq raised", 32'(irq), 32'h1);
    chk("dma raised", 32'(dma_req[0]), 32'h1);
    cfe_host_model_inst.rd(`CFE_OFF_STATUS, v, r);
    chk("status both", {27'h0, v[4:0]}, 32'h3);
    cfe_host_model_inst.rd(`CFE_OFF_CH1 + 12'h8, v, r);
    chk("out1", v, 32'(y));
    cfe_host_model_inst.rd(`CFE_OFF_CH0 + 12'h8, v, r);
    chk("out0 shared", v, fir_out());
    repeat (3) @(posedge aclk);
    chk("irq cleared", 32'(irq), 32'h0);
    chk("dma cleared", 32'(dma_req[0]), 32'h0);
    $display("test both channels done");
    final_report();
  end
endmodule : dual_channel_cascade_filter_engine_test
